// ==== common/cpsi_pkg.sv ====
// package of register map, field positions and timing for cpsi register bank
package cpsi_pkg;

  // register addresses on the serial control bus
  localparam logic [7:0] CPSI_ISR_ADDR    = 8'hC7;
  localparam logic [7:0] CPSI_VERIFY_ADDR = 8'hC8;
  localparam logic [7:0] CPSI_BLUE_ADDR   = 8'hCE;
  localparam logic [7:0] CPSI_IND_ADDR    = 8'hD0;

  // interrupt status fields
  localparam int CPSI_IS_INDIRECT = 7;
  localparam int CPSI_IS_RXDET    = 6;
  localparam int CPSI_IS_DOWN     = 5;
  localparam int CPSI_IS_LIST     = 4;
  localparam int CPSI_IS_VECTOR   = 3;
  localparam int CPSI_IS_FAIL     = 2;
  localparam int CPSI_IS_PASS     = 1;
  localparam int CPSI_IS_GLOBAL   = 0;
  localparam int CPSI_GLOBAL_EN   = 0;

  // key-store verify control fields
  localparam int CPSI_VFY_PASS  = 7;
  localparam int CPSI_VFY_DONE  = 6;
  localparam int CPSI_VFY_START = 2;
  localparam logic [7:0] CPSI_VFY_SPARE_MASK = 8'h23;

  // indirect access status and control fields
  localparam int CPSI_IND_RESET   = 7;
  localparam int CPSI_IND_SPEEDUP = 6;
  localparam int CPSI_IND_TO_DIS  = 5;
  localparam int CPSI_IND_FAST    = 4;
  localparam int CPSI_IND_ACK     = 1;
  localparam int CPSI_IND_DONE    = 0;

  // reset values
  localparam logic [7:0] CPSI_ZERO_BYTE  = 8'h00;
  localparam logic [7:0] CPSI_BLUE_RESET = 8'hFF;

  // timing
  localparam int CPSI_CLK_MHZ          = 50;
  localparam int CPSI_IDLE_TIMEOUT_US  = 1000000;
  localparam int CPSI_SPEEDUP_US       = 50;
  localparam int CPSI_IDLE_CYCLES      = CPSI_IDLE_TIMEOUT_US * CPSI_CLK_MHZ;
  localparam int CPSI_SPEEDUP_CYCLES   = CPSI_SPEEDUP_US * CPSI_CLK_MHZ;
  localparam int CPSI_TIMER_W          = 26;

  // one register access from the serial control bus slave
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cpsi_reg_req_t;

  // one-cycle event pulses from the content-protection engine
  typedef struct packed {
    logic downstream_irq;
    logic vector_list_ready;
    logic vector_ready;
    logic auth_fail;
    logic auth_pass;
  } cpsi_events_t;

  function automatic logic cpsi_hit(input cpsi_reg_req_t req,
                                    input logic [7:0]    addr);
    cpsi_hit = (req.addr == addr);
  endfunction

endpackage

// ==== tb/cpsi_host_model.sv ====
// host controller model issuing register cycles on the control bus
`timescale 1ns/1ns
module cpsi_host_model
  import cpsi_pkg::*;
(
  input  wire logic       clk_sys,
  output cpsi_reg_req_t   reg_req,
  input  wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  // a released bus shows the inverse of the last cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask
endmodule // cpsi_host_model

// ==== tb/cpsi_regs_tb.sv ====
// testbench of the cpsi register bank
`timescale 1ns/1ns
module cpsi_regs_tb
  import cpsi_pkg::*;
;
  logic          clk_sys, resetn, irq_n, rx_detect, rx_lock, wait_lock;
  logic          ind_start, ind_cmp, ind_ack, ind_rv, bus_act, mrst;
  logic          to_dis, spdup, fast, bus_free, restart, hwv, dvalid;
  logic          blue_on;
  cpsi_reg_req_t reg_req;
  cpsi_events_t  ev;
  logic [7:0]    reg_rdata, irq_enable, ind_byte, ind_data, pix, blue;
  logic [7:0]    d;
  logic [5:0]    key_addr;
  logic [31:0]   key_data, hash_word;
  logic [159:0]  digest, stored;
  int            errors, compares, words, mcount, sum;

  cpsi_host_model cpsi_host_model_i (.clk_sys(clk_sys), .reg_req(reg_req),
    .reg_rdata(reg_rdata));

  cpsi_regs #(.IDLE_CYCLES(5000)) cpsi_regs_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .irq_enable(irq_enable), .irq_n(irq_n),
    .events(ev), .rx_detect(rx_detect), .rx_lock(rx_lock),
    .receiver_detect_wait_lock(wait_lock), .ind_access_start(ind_start),
    .ind_access_complete(ind_cmp), .ind_ack_in(ind_ack),
    .ind_read_valid(ind_rv), .ind_read_byte(ind_byte),
    .indirect_data_byte(ind_data), .bus_activity(bus_act),
    .remote_master_reset(mrst), .bus_timeout_disable(to_dis),
    .idle_timer_speedup(spdup), .remote_fast_mode(fast),
    .bus_free(bus_free), .key_addr(key_addr), .key_data(key_data),
    .hash_restart(restart), .hash_word_valid(hwv), .hash_word(hash_word),
    .digest_valid(dvalid), .digest(digest), .stored_digest(stored),
    .blue_screen_active(blue_on), .pixel_blue(pix), .blue_channel(blue));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // key store answers one cycle after the address; hashed words summed
  always @(posedge clk_sys) begin
    key_data <= {26'h0, key_addr};
    if (mrst) mcount++;
    if (restart) begin
      words = 0;
      sum = 0;
    end else if (hwv) begin
      words++;
      sum += int'(hash_word);
    end
  end

  task automatic close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] got,
                     input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    cpsi_host_model_i.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    rchk(CPSI_ISR_ADDR, 8'h00);
    rchk(CPSI_VERIFY_ADDR, 8'h00);
    rchk(CPSI_BLUE_ADDR, 8'hFF);
    rchk(CPSI_IND_ADDR, 8'h00);
    rchk(8'hC9, 8'h00);
    chk("irq_n", irq_n, 1);
  endtask

  task automatic t_events;
    for (int k = 0; k < 5; k++) begin
      ev <= cpsi_events_t'(5'(1 << k));
      tick(1);
      ev <= '0;
      tick(2);
      @(negedge clk_sys);
      chk("irq_n", irq_n, 0);
      rchk(CPSI_ISR_ADDR, 8'(2 << k) | 8'h01);
      rchk(CPSI_ISR_ADDR, 8'h00);
    end
    irq_enable <= 8'h01;
    ev <= '{auth_pass: 1'b1, default: 1'b0};
    tick(1);
    ev <= '0;
    tick(2);
    @(negedge clk_sys);
    chk("irq_n", irq_n, 1);
    rchk(CPSI_ISR_ADDR, 8'h02);
    irq_enable <= 8'hFE;
    ev <= '{auth_fail: 1'b1, default: 1'b0};
    tick(1);
    ev <= '0;
    tick(2);
    @(negedge clk_sys);
    chk("irq_n", irq_n, 1);
    rchk(CPSI_ISR_ADDR, 8'h05);
    irq_enable <= 8'hFF;
  endtask

  task automatic t_rxdet;
    wait_lock <= 1'b1;
    rx_detect <= 1'b1;
    tick(3);
    rchk(CPSI_ISR_ADDR, 8'h00);
    rx_lock <= 1'b1;
    tick(3);
    rchk(CPSI_ISR_ADDR, 8'h41);
    {wait_lock, rx_detect, rx_lock} <= 3'b000;
    tick(2);
    rx_detect <= 1'b1;
    tick(3);
    rchk(CPSI_ISR_ADDR, 8'h41);
    rx_detect <= 1'b0;
  endtask

  task automatic t_indirect(input logic ack, input logic [7:0] st);
    // target address and read direction set up before the access
    cpsi_host_model_i.wr(8'hD1, 8'hA1);
    ind_start <= 1'b1;
    tick(1);
    ind_start <= 1'b0;
    {ind_cmp, ind_ack, ind_rv} <= {1'b1, ack, 1'b1};
    ind_byte <= 8'hA5;
    tick(1);
    {ind_cmp, ind_ack, ind_rv} <= 3'b000;
    ind_byte <= 8'h5A;
    tick(1);
    rchk(CPSI_IND_ADDR, st);
    rchk(CPSI_ISR_ADDR, 8'h81);
    chk("read byte", ind_data, 8'hA5);
    rchk(CPSI_IND_ADDR, st & 8'h02);
  endtask

  task automatic t_ctrl;
    cpsi_host_model_i.wr(CPSI_IND_ADDR, 8'h70);
    chk("modes", {fast, to_dis, spdup}, 3'b111);
    cpsi_host_model_i.wr(CPSI_IND_ADDR, 8'hE0);
    chk("modes", {fast, to_dis, spdup}, 3'b011);
    rchk(CPSI_IND_ADDR, 8'h60);
    chk("master resets", mcount, 1);
  endtask

  task automatic t_idle(input logic [7:0] c, input int n, input logic fr);
    cpsi_host_model_i.wr(CPSI_IND_ADDR, c);
    bus_act <= 1'b1;
    tick(2);
    bus_act <= 1'b0;
    tick(n - 20);
    @(negedge clk_sys);
    chk("bus_free", bus_free, 0);
    tick(40);
    @(negedge clk_sys);
    chk("bus_free", bus_free, fr);
  endtask

  task automatic t_verify(input logic [7:0] c, input logic ok,
                          input logic [7:0] exp);
    int i;
    cpsi_host_model_i.wr(CPSI_VERIFY_ADDR, c);
    rchk(CPSI_VERIFY_ADDR, c);
    i = 0;
    while (words < 64 && i < 400) begin
      tick(1);
      i++;
    end
    tick(3);
    chk("words", words, 64);
    chk("word sum", sum, 16'h07E0);
    digest <= ok ? stored : ~stored;
    dvalid <= 1'b1;
    tick(1);
    dvalid <= 1'b0;
    tick(2);
    rchk(CPSI_VERIFY_ADDR, exp);
  endtask

  task automatic t_blue;
    cpsi_host_model_i.wr(CPSI_BLUE_ADDR, 8'h3C);
    blue_on <= 1'b1;
    pix <= 8'h99;
    tick(2);
    @(negedge clk_sys);
    chk("blue", blue, 8'h3C);
    blue_on <= 1'b0;
    tick(2);
    @(negedge clk_sys);
    chk("blue", blue, 8'h99);
    rchk(CPSI_BLUE_ADDR, 8'h3C);
    cpsi_host_model_i.wr(CPSI_ISR_ADDR, 8'hFF);
    rchk(CPSI_ISR_ADDR, 8'h00);
  endtask

  initial begin
    {resetn, rx_detect, rx_lock, wait_lock, ind_start, ind_cmp} = '0;
    {ind_ack, ind_rv, bus_act, dvalid, blue_on} = '0;
    {errors, compares, words, mcount, sum} = '0;
    ev = '0;
    irq_enable = 8'hFF;
    ind_byte = 8'h00;
    pix = 8'h00;
    digest = '0;
    stored = {5{32'hC3A5_5A3C}};
    tick(2);
    resetn <= 1'b1;
    tick(1);
    t_reset();
    t_events();
    t_rxdet();
    t_indirect(1'b1, 8'h03);
    t_indirect(1'b0, 8'h01);
    t_ctrl();
    t_idle(8'h40, 2500, 1'b1);
    t_idle(8'h20, 5100, 1'b0);
    t_idle(8'h00, 5000, 1'b1);
    t_verify(8'h04, 1'b1, 8'hC0);
    t_verify(8'h27, 1'b0, 8'h63);
    t_blue();
    close_out();
  end

  initial begin
    #(30000 * 20);
    errors++;
    close_out();
  end
endmodule // cpsi_regs_tb

// ==== verilog/cpsi_idle_timer.sv ====
// bus idle timer of the remote i2c master
`timescale 1ns/1ns
module cpsi_idle_timer
  import cpsi_pkg::*;
#(
  parameter int LONG_CYCLES  = CPSI_IDLE_CYCLES,
  parameter int SHORT_CYCLES = CPSI_SPEEDUP_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic bus_activity,
  input  wire logic master_reset,
  input  wire logic timeout_disable,
  input  wire logic speedup,
  output logic      bus_free
);

  logic [CPSI_TIMER_W-1:0] count;
  logic [CPSI_TIMER_W-1:0] limit;
  logic                    expired;

  assign limit = speedup ? CPSI_TIMER_W'(SHORT_CYCLES)
                         : CPSI_TIMER_W'(LONG_CYCLES);
  assign expired = (count >= limit);

  // counts idle cycles, restarts on any bus signalling
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (bus_activity || master_reset || timeout_disable) begin
      count <= '0;
    end else if (!expired) begin
      count <= count + CPSI_TIMER_W'(1);
    end
  end

  // bus declared free once idle longer than the limit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_free <= 1'b0;
    end else begin
      bus_free <= expired && !bus_activity && !timeout_disable;
    end
  end

  no_free_disabled_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    timeout_disable |=> !bus_free)
    else $error("bus free reported with timeout disabled");

  short_limit_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (speedup && !timeout_disable && !bus_activity && !master_reset
     && count == CPSI_TIMER_W'(SHORT_CYCLES - 1)) ##1
    (!bus_activity && !timeout_disable && speedup) |=> bus_free)
    else $error("speedup timeout did not expire on time");

endmodule // cpsi_idle_timer

// ==== verilog/cpsi_regs.sv ====
// content-protection status, key verify and indirect access registers
//
// Behaviour
// - set status bit 7 when an indirect access finishes
// - set status bit 6 on receiver detect, or on lock when selected
// - set status bit 5 on interrupt forwarded from downstream
// - set status bit 4 when the vector list is readable
// - set status bit 3 when the receiver vector is readable
// - set status bit 2 on authentication failure or loss
// - set status bit 1 on authentication success
// - status bit 0 shows any enabled status bit currently set
// - verify start hashes all keys, compares, then clears itself
// - verify done flag rises when verification completes
// - pass flag gives the result, valid only while done is set
// - blue channel carries the fill byte during blue screen, reset FF
// - writing 1 to bit 7 resets the remote i2c master
// - bus taken as free after 1 s idle unless timeout disabled
// - speedup bit cuts the idle timeout to 50 us
// - bit 4 selects fast or standard timing for the remote master
// - ack flag set only on a valid acknowledge at transfer end
// - done flag set on completion, cleared by read or new access
// - read byte returned by the device, kept until the next valid read
// - interrupt output driven only with global enable set
`timescale 1ns/1ns
module cpsi_regs
  import cpsi_pkg::*;
#(
  parameter int IDLE_CYCLES = CPSI_IDLE_CYCLES,
  parameter int KEY_WORDS   = 64,
  parameter int KEY_AW      = 6,
  parameter int KEY_W       = 32,
  parameter int DIGEST_W    = 160
) (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire cpsi_reg_req_t       reg_req,
  output logic [7:0]               reg_rdata,
  input  wire logic [7:0]          irq_enable,
  output logic                     irq_n,
  input  wire cpsi_events_t        events,
  input  wire logic                rx_detect,
  input  wire logic                rx_lock,
  input  wire logic                receiver_detect_wait_lock,
  input  wire logic                ind_access_start,
  input  wire logic                ind_access_complete,
  input  wire logic                ind_ack_in,
  input  wire logic                ind_read_valid,
  input  wire logic [7:0]          ind_read_byte,
  output logic [7:0]               indirect_data_byte,
  input  wire logic                bus_activity,
  output logic                     remote_master_reset,
  output logic                     bus_timeout_disable,
  output logic                     idle_timer_speedup,
  output logic                     remote_fast_mode,
  output logic                     bus_free,
  output logic [KEY_AW-1:0]        key_addr,
  input  wire logic [KEY_W-1:0]    key_data,
  output logic                     hash_restart,
  output logic                     hash_word_valid,
  output logic [KEY_W-1:0]         hash_word,
  input  wire logic                digest_valid,
  input  wire logic [DIGEST_W-1:0] digest,
  input  wire logic [DIGEST_W-1:0] stored_digest,
  input  wire logic                blue_screen_active,
  input  wire logic [7:0]          pixel_blue,
  output logic [7:0]               blue_channel
);

  typedef enum logic [2:0] {
    CPSI_V_IDLE  = 3'b001,
    CPSI_V_FETCH = 3'b010,
    CPSI_V_WAIT  = 3'b100
  } cpsi_vstate_t;

  cpsi_vstate_t vstate;
  logic [7:1]   isr_sticky;
  logic [7:1]   isr_set;
  logic [7:1]   next_isr;
  logic         isr_global;
  logic         next_global;
  logic         isr_read;
  logic         ind_read;
  logic         rxdet_qual;
  logic         rxdet_prev;
  logic         rxdet_rise;
  logic         verify_start;
  logic         verify_done;
  logic         verify_pass;
  logic [7:0]   verify_spare;
  logic         fetch_pend;
  logic         start_req;
  logic [7:0]   blue_fill;
  logic         ind_done;
  logic         ind_ack;
  logic [7:0]   read_value;

  assign isr_read = reg_req.rd && cpsi_hit(reg_req, CPSI_ISR_ADDR);
  assign ind_read = reg_req.rd && cpsi_hit(reg_req, CPSI_IND_ADDR);
  assign start_req = reg_req.wr && cpsi_hit(reg_req, CPSI_VERIFY_ADDR)
                     && reg_req.wdata[CPSI_VFY_START];

  // receiver detect, optionally qualified by receiver lock
  assign rxdet_qual = receiver_detect_wait_lock ? (rx_detect && rx_lock)
                                                : rx_detect;
  assign rxdet_rise = rxdet_qual && !rxdet_prev;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxdet_prev <= 1'b0;
    end else begin
      rxdet_prev <= rxdet_qual;
    end
  end

  // status events; a set in the read cycle survives the clear-on-read
  always_comb begin
    isr_set                   = '0;
    isr_set[CPSI_IS_INDIRECT] = ind_access_complete;
    isr_set[CPSI_IS_RXDET]    = rxdet_rise;
    isr_set[CPSI_IS_DOWN]     = events.downstream_irq;
    isr_set[CPSI_IS_LIST]     = events.vector_list_ready;
    isr_set[CPSI_IS_VECTOR]   = events.vector_ready;
    isr_set[CPSI_IS_FAIL]     = events.auth_fail;
    isr_set[CPSI_IS_PASS]     = events.auth_pass;
    next_isr    = (isr_read ? '0 : isr_sticky) | isr_set;
    next_global = |(next_isr & irq_enable[7:1]);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      isr_sticky <= '0;
      isr_global <= 1'b0;
    end else begin
      isr_sticky <= next_isr;
      isr_global <= next_global;
    end
  end

  // interrupt pin, active low, gated by the global enable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(next_global && irq_enable[CPSI_GLOBAL_EN]);
    end
  end

  // key-store verify sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vstate       <= CPSI_V_IDLE;
      verify_start <= 1'b0;
      verify_done  <= 1'b0;
      verify_pass  <= 1'b0;
      key_addr     <= '0;
      hash_restart <= 1'b0;
    end else begin
      hash_restart <= 1'b0;
      unique case (vstate)
        CPSI_V_IDLE: begin
          if (start_req) begin
            vstate       <= CPSI_V_FETCH;
            verify_start <= 1'b1;
            verify_done  <= 1'b0;
            verify_pass  <= 1'b0;
            key_addr     <= '0;
            hash_restart <= 1'b1;
          end
        end
        CPSI_V_FETCH: begin
          if (key_addr == KEY_AW'(KEY_WORDS - 1)) begin
            vstate <= CPSI_V_WAIT;
          end else begin
            key_addr <= key_addr + KEY_AW'(1);
          end
        end
        CPSI_V_WAIT: begin
          if (digest_valid && !fetch_pend) begin
            vstate       <= CPSI_V_IDLE;
            verify_start <= 1'b0;
            verify_done  <= 1'b1;
            verify_pass  <= (digest == stored_digest);
          end
        end
      endcase
    end
  end

  // key words arrive one cycle after their address, then go to the hash
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fetch_pend      <= 1'b0;
      hash_word_valid <= 1'b0;
      hash_word       <= '0;
    end else begin
      fetch_pend      <= (vstate == CPSI_V_FETCH);
      hash_word_valid <= fetch_pend;
      hash_word       <= fetch_pend ? key_data : hash_word;
    end
  end

  // spare verify control bits keep what software writes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      verify_spare <= CPSI_ZERO_BYTE;
    end else if (reg_req.wr && cpsi_hit(reg_req, CPSI_VERIFY_ADDR)) begin
      verify_spare <= reg_req.wdata & CPSI_VFY_SPARE_MASK;
    end
  end

  // blue screen fill value and blue channel mux
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      blue_fill <= CPSI_BLUE_RESET;
    end else if (reg_req.wr && cpsi_hit(reg_req, CPSI_BLUE_ADDR)) begin
      blue_fill <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      blue_channel <= CPSI_ZERO_BYTE;
    end else begin
      blue_channel <= blue_screen_active ? blue_fill : pixel_blue;
    end
  end

  // indirect access control bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      remote_master_reset <= 1'b0;
      idle_timer_speedup  <= 1'b0;
      bus_timeout_disable <= 1'b0;
      remote_fast_mode    <= 1'b0;
    end else if (reg_req.wr && cpsi_hit(reg_req, CPSI_IND_ADDR)) begin
      remote_master_reset <= reg_req.wdata[CPSI_IND_RESET];
      idle_timer_speedup  <= reg_req.wdata[CPSI_IND_SPEEDUP];
      bus_timeout_disable <= reg_req.wdata[CPSI_IND_TO_DIS];
      remote_fast_mode    <= reg_req.wdata[CPSI_IND_FAST];
    end else begin
      remote_master_reset <= 1'b0;
    end
  end

  // indirect access done and acknowledge flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ind_done <= 1'b0;
      ind_ack  <= 1'b0;
    end else begin
      if (ind_access_complete) begin
        ind_done <= 1'b1;
        ind_ack  <= ind_ack_in;
      end else if (ind_access_start) begin
        ind_done <= 1'b0;
        ind_ack  <= 1'b0;
      end else if (ind_read) begin
        ind_done <= 1'b0;
      end
    end
  end

  // byte returned by a successful indirect read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      indirect_data_byte <= CPSI_ZERO_BYTE;
    end else if (ind_read_valid) begin
      indirect_data_byte <= ind_read_byte;
    end
  end

  cpsi_idle_timer #(
    .LONG_CYCLES  (IDLE_CYCLES),
    .SHORT_CYCLES (CPSI_SPEEDUP_CYCLES)
  ) cpsi_idle_timer_i (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .bus_activity    (bus_activity),
    .master_reset    (remote_master_reset),
    .timeout_disable (bus_timeout_disable),
    .speedup         (idle_timer_speedup),
    .bus_free        (bus_free)
  );

  // read data mux; unmapped addresses read as zero
  always_comb begin
    read_value = CPSI_ZERO_BYTE;
    unique case (reg_req.addr)
      CPSI_ISR_ADDR: begin
        read_value[7:1]            = isr_sticky;
        read_value[CPSI_IS_GLOBAL] = isr_global;
      end
      CPSI_VERIFY_ADDR: begin
        read_value                 = verify_spare;
        read_value[CPSI_VFY_PASS]  = verify_pass;
        read_value[CPSI_VFY_DONE]  = verify_done;
        read_value[CPSI_VFY_START] = verify_start;
      end
      CPSI_BLUE_ADDR: begin
        read_value = blue_fill;
      end
      CPSI_IND_ADDR: begin
        read_value[CPSI_IND_SPEEDUP] = idle_timer_speedup;
        read_value[CPSI_IND_TO_DIS]  = bus_timeout_disable;
        read_value[CPSI_IND_FAST]    = remote_fast_mode;
        read_value[CPSI_IND_ACK]     = ind_ack;
        read_value[CPSI_IND_DONE]    = ind_done;
      end
      default: begin
        read_value = CPSI_ZERO_BYTE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= CPSI_ZERO_BYTE;
    end else if (reg_req.rd) begin
      reg_rdata <= read_value;
    end
  end

  indirect_status_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ind_access_complete |=> isr_sticky[CPSI_IS_INDIRECT])
    else $error("indirect completion not flagged in status");

  receiver_detect_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (receiver_detect_wait_lock && rx_detect && !rx_lock && !rxdet_prev
     && !isr_sticky[CPSI_IS_RXDET]) |=> !isr_sticky[CPSI_IS_RXDET])
    else $error("receiver detect flagged before lock");

  event_status_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (|{events.downstream_irq, events.vector_list_ready,
       events.vector_ready, events.auth_fail, events.auth_pass})
    |=> ((isr_sticky[5:1] & $past({events.downstream_irq,
          events.vector_list_ready, events.vector_ready,
          events.auth_fail, events.auth_pass}))
         == $past({events.downstream_irq, events.vector_list_ready,
          events.vector_ready, events.auth_fail, events.auth_pass})))
    else $error("engine event lost from status");

  global_flag_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ##1 (isr_global == |(isr_sticky & $past(irq_enable[7:1]))))
    else $error("global status does not match enabled bits");

  irq_gate_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ##1 (!irq_n == (isr_global && $past(irq_enable[CPSI_GLOBAL_EN]))))
    else $error("interrupt pin disagrees with global enable");

  verify_finish_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (vstate == CPSI_V_WAIT && digest_valid && !fetch_pend)
    |=> (!verify_start && verify_done && vstate == CPSI_V_IDLE))
    else $error("verify did not finish on digest");

  verify_result_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(verify_done) |-> verify_pass == $past(digest == stored_digest))
    else $error("verify pass flag does not match compare");

  blue_fill_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    blue_screen_active |=> blue_channel == $past(blue_fill))
    else $error("blue channel not carrying fill value");

  master_reset_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_req.wr && reg_req.addr == CPSI_IND_ADDR
     && reg_req.wdata[CPSI_IND_RESET]) |=> remote_master_reset ##1
    (!remote_master_reset || $past(reg_req.wr)))
    else $error("remote master reset pulse wrong");

  ack_flag_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ind_access_complete |=> ind_ack == $past(ind_ack_in))
    else $error("ack flag does not follow acknowledge");

  done_clear_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ind_read && !ind_access_complete) |=> !ind_done)
    else $error("indirect done not cleared by read");

endmodule // cpsi_regs
